//--- balu_core.sv
// Byte arithmetic and logic datapath with register file and bus slave
//
// Functional notes
// - Add two registers, optional carry in; flags Z C N V H; one cycle.
// - Subtract register, optional borrow; flags Z C N V H; one cycle.
// - Subtract immediate from destination; flags Z C N V H; one cycle.
// - Subtract immediate plus carry; flags Z C N V H; one cycle.
// - Add immediate to register pair; flags Z C N V S; two cycles.
// - Subtract immediate from register pair; flags Z C N V S; two cycles.
// - AND with register or immediate; flags Z N V only; one cycle.
// - OR with register or immediate; flags Z N V only; one cycle.
// - Set mask bits by OR of immediate; flags Z N V; one cycle.
// - Clear mask bits by AND with 0xFF minus immediate; one cycle.
// - Test register: AND with itself, value kept, flags Z N V.
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
module balu_core (
  input wire logic clk,
  input wire logic arst_n,
  input wire balu_pkg::balu_req_type req,
  output logic req_ready_r,
  output logic done_r,
  output balu_pkg::balu_flags_type flags_r,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ==========================================================================
  // Arithmetic core
  function automatic balu_pkg::balu_arith_type arith(
    input logic [7:0] a,
    input logic [7:0] b,
    input logic cin,
    input logic sub
  );
    logic [8:0] t;
    logic [7:0] r;
    balu_pkg::balu_arith_type o;
    t = sub ? ({1'h0, a} - {1'h0, b} - {8'h00, cin})
            : ({1'h0, a} + {1'h0, b} + {8'h00, cin});
    r = t[7:0];
    o.r = r;
    o.c = t[8];
    o.h = sub ? ((~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]))
              : ((a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]));
    o.v = sub ? ((a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]))
              : ((a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]));
    return o;
  endfunction : arith

  // ==========================================================================
  // State
  logic [7:0] rf_r [32];
  balu_pkg::balu_state_type state_r;
  balu_pkg::balu_state_type state_nxt;
  logic [4:0] word_dst_r;
  logic word_c_r;
  logic word_sub_r;
  logic ack_r;
  logic [31:0] dat_r;

  logic take;
  logic [7:0] rd_val;
  logic [7:0] src_val;
  logic [7:0] opd;
  logic [4:0] hi_idx;
  logic [7:0] res;
  logic [4:0] wr_idx;
  logic wr_en;
  logic fl_en;
  logic op_done;
  logic lo_c;
  balu_pkg::balu_flags_type fl_nxt;
  balu_pkg::balu_arith_type ar;
  logic [15:0] wres;
  logic bus_go;
  logic [31:0] rdata;

  assign take = req.valid && req_ready_r;
  assign rd_val = rf_r[req.dst];
  assign src_val = rf_r[req.src];
  assign hi_idx = 5'(word_dst_r + 5'h01);
  assign opd = (req.op inside {balu_pkg::OP_SUB_IMM,
                balu_pkg::OP_SUB_IMM_BORROW, balu_pkg::OP_AND_IMM,
                balu_pkg::OP_OR_IMM, balu_pkg::OP_SET_MASK,
                balu_pkg::OP_CLEAR_MASK}) ? req.imm : src_val;

  // ==========================================================================
  // Operation decode and flag computation
  always_comb begin
    state_nxt = state_r;
    res = rd_val;
    wr_idx = req.dst;
    wr_en = 1'b0;
    fl_en = 1'b0;
    op_done = 1'b0;
    lo_c = 1'b0;
    fl_nxt = flags_r;
    ar = '0;
    wres = '0;
    case (state_r)
      balu_pkg::ST_IDLE: begin
        if (take) begin
          case (req.op)
            balu_pkg::OP_ADD, balu_pkg::OP_ADC: begin
              ar = arith(rd_val, opd,
                         (req.op == balu_pkg::OP_ADC) & flags_r.c, 1'b0);
              res = ar.r;
              fl_nxt.z = (ar.r == balu_pkg::BYTE_ZERO);
            end
            balu_pkg::OP_SUB, balu_pkg::OP_SUB_BORROW,
            balu_pkg::OP_SUB_IMM, balu_pkg::OP_SUB_IMM_BORROW: begin
              lo_c = (req.op inside {balu_pkg::OP_SUB_BORROW,
                      balu_pkg::OP_SUB_IMM_BORROW});
              ar = arith(rd_val, opd, lo_c & flags_r.c, 1'h1);
              res = ar.r;
              fl_nxt.z = (ar.r == balu_pkg::BYTE_ZERO) & (~lo_c | flags_r.z);
            end
            // Low byte now, high byte next cycle
            balu_pkg::OP_WORD_ADD, balu_pkg::OP_WORD_SUB: begin
              ar = arith(rd_val, req.imm, 1'h0,
                         req.op == balu_pkg::OP_WORD_SUB);
              res = ar.r;
              state_nxt = balu_pkg::ST_WORD_HI;
            end
            // Logical AND, test keeps the value
            balu_pkg::OP_AND, balu_pkg::OP_AND_IMM,
            balu_pkg::OP_TEST_REG: begin
              res = (req.op == balu_pkg::OP_TEST_REG) ? rd_val : rd_val & opd;
            end
            // Logical OR and set mask bits
            balu_pkg::OP_OR, balu_pkg::OP_OR_IMM,
            balu_pkg::OP_SET_MASK: begin
              res = rd_val | opd;
            end
            balu_pkg::OP_CLEAR_MASK: begin
              res = rd_val & (balu_pkg::BYTE_ALL - req.imm);
            end
            default: begin
              res = rd_val;
            end
          endcase
          if (req.op != balu_pkg::OP_NOP) begin
            wr_en = 1'b1;
            op_done = (state_nxt == balu_pkg::ST_IDLE);
            fl_en = op_done;
          end
          // Only the listed flags are written
          if (req.op inside {balu_pkg::OP_ADD, balu_pkg::OP_ADC,
              balu_pkg::OP_SUB, balu_pkg::OP_SUB_BORROW, balu_pkg::OP_SUB_IMM,
              balu_pkg::OP_SUB_IMM_BORROW}) begin
            fl_nxt.c = ar.c;
            fl_nxt.h = ar.h;
            fl_nxt.v = ar.v;
            fl_nxt.n = ar.r[7];
          end else if (req.op inside {balu_pkg::OP_AND, balu_pkg::OP_AND_IMM,
              balu_pkg::OP_OR, balu_pkg::OP_OR_IMM, balu_pkg::OP_SET_MASK,
              balu_pkg::OP_CLEAR_MASK, balu_pkg::OP_TEST_REG}) begin
            fl_nxt.v = 1'b0;
            fl_nxt.n = res[7];
            fl_nxt.z = (res == balu_pkg::BYTE_ZERO);
          end
        end
      end
      // High byte and word flags, S written only here
      balu_pkg::ST_WORD_HI: begin
        ar = arith(rf_r[hi_idx], balu_pkg::BYTE_ZERO, word_c_r, word_sub_r);
        res = ar.r;
        wr_idx = hi_idx;
        wr_en = 1'b1;
        fl_en = 1'b1;
        op_done = 1'b1;
        wres = {ar.r, rf_r[word_dst_r]};
        fl_nxt.n = wres[15];
        fl_nxt.z = (wres == 16'h0000);
        fl_nxt.v = word_sub_r ? (rf_r[hi_idx][7] & ~wres[15])
                              : (~rf_r[hi_idx][7] & wres[15]);
        fl_nxt.c = word_sub_r ? (wres[15] & ~rf_r[hi_idx][7])
                              : (~wres[15] & rf_r[hi_idx][7]);
        fl_nxt.s = fl_nxt.n ^ fl_nxt.v;
        state_nxt = balu_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = balu_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Sequencing
  // Ready stays low while the high byte of a word is pending
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= balu_pkg::ST_IDLE;
      req_ready_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_ready_r <= (state_nxt == balu_pkg::ST_IDLE);
      done_r <= op_done;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      word_dst_r <= 5'h00;
      word_c_r <= 1'b0;
      word_sub_r <= 1'b0;
    end else if (take && state_nxt == balu_pkg::ST_WORD_HI) begin
      word_dst_r <= req.dst;
      word_c_r <= ar.c;
      word_sub_r <= (req.op == balu_pkg::OP_WORD_SUB);
    end
  end

  // ==========================================================================
  // Register file and flags; datapath writes win over the bus
  assign bus_go = wb_cyc_i && wb_stb_i && !ack_r && !wr_en;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      rf_r[wr_idx] <= res;
    end else if (bus_go && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i <= balu_pkg::ADR_RF_LAST) begin
      rf_r[wb_adr_i[6:2]] <= wb_dat_i[7:0];
    end
  end

  // Software may preload carry for a chained add or subtract
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= balu_pkg::STATUS_RST[5:0];
    end else if (fl_en) begin
      flags_r <= fl_nxt;
    end else if (bus_go && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i[7:2] == balu_pkg::ADR_STATUS[7:2]) begin
      flags_r <= wb_dat_i[5:0];
    end
  end

  // ==========================================================================
  // Bus slave; unmapped reads give zero and writes are dropped
  always_comb begin
    rdata = 32'h0000_0000;
    if (wb_adr_i <= balu_pkg::ADR_RF_LAST) begin
      rdata = {24'h00_0000, rf_r[wb_adr_i[6:2]]};
    end else if (wb_adr_i[7:2] == balu_pkg::ADR_STATUS[7:2]) begin
      rdata = {26'h000_0000, flags_r};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_go;
      if (bus_go) begin
        dat_r <= rdata;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ==========================================================================
  // Checks
  logic [15:0] exp_word_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exp_word_r <= 16'h0000;
    end else if (take && state_nxt == balu_pkg::ST_WORD_HI) begin
      exp_word_r <= (req.op == balu_pkg::OP_WORD_SUB)
        ? 16'({rf_r[5'(req.dst + 5'h01)], rd_val} - {8'h00, req.imm})
        : 16'({rf_r[5'(req.dst + 5'h01)], rd_val} + {8'h00, req.imm});
    end
  end

  add_result_a: assert property (@(posedge clk) disable iff (!arst_n)
    take && req.op == balu_pkg::OP_ADD |=>
    rf_r[$past(req.dst)] == 8'($past(rd_val) + $past(src_val)))
    else $error("add result wrong");

  sub_carry_a: assert property (@(posedge clk) disable iff (!arst_n)
    take && req.op == balu_pkg::OP_SUB |=>
    flags_r.c == ($past(rd_val) < $past(src_val)))
    else $error("subtract borrow wrong");

  imm_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    take && req.op == balu_pkg::OP_SUB_IMM |=>
    flags_r.z == ($past(rd_val) == $past(req.imm)) && done_r)
    else $error("subtract immediate zero wrong");

  borrow_chain_a: assert property (@(posedge clk) disable iff (!arst_n)
    take && req.op == balu_pkg::OP_SUB_IMM_BORROW |=>
    flags_r.c == ({1'b0, $past(rd_val)} <
                  ({1'b0, $past(req.imm)} + 9'($past(flags_r.c)))))
    else $error("borrow chain wrong");

  word_timing_a: assert property (@(posedge clk) disable iff (!arst_n)
    take && req.op inside {balu_pkg::OP_WORD_ADD, balu_pkg::OP_WORD_SUB} |=>
    !req_ready_r && !done_r ##1 req_ready_r && done_r)
    else $error("word operation timing wrong");

  word_sum_a: assert property (@(posedge clk) disable iff (!arst_n)
    state_r == balu_pkg::ST_WORD_HI |=>
    {rf_r[hi_idx], rf_r[word_dst_r]} == exp_word_r &&
    flags_r.s == (flags_r.n ^ flags_r.v))
    else $error("word result wrong");

  logic_flags_a: assert property (@(posedge clk) disable iff (!arst_n)
    take && req.op inside {balu_pkg::OP_AND, balu_pkg::OP_AND_IMM,
    balu_pkg::OP_OR, balu_pkg::OP_OR_IMM} |=>
    !flags_r.v && flags_r.n == rf_r[$past(req.dst)][7])
    else $error("logic flags wrong");

  keep_flags_a: assert property (@(posedge clk) disable iff (!arst_n)
    take && req.op inside {balu_pkg::OP_AND, balu_pkg::OP_OR,
    balu_pkg::OP_SET_MASK, balu_pkg::OP_CLEAR_MASK, balu_pkg::OP_TEST_REG} |=>
    $stable(flags_r.c) && $stable(flags_r.h) && $stable(flags_r.s))
    else $error("untouched flag changed");

  set_bits_a: assert property (@(posedge clk) disable iff (!arst_n)
    take && req.op == balu_pkg::OP_SET_MASK |=>
    rf_r[$past(req.dst)] == ($past(rd_val) | $past(req.imm)))
    else $error("set bits wrong");

  clear_bits_a: assert property (@(posedge clk) disable iff (!arst_n)
    take && req.op == balu_pkg::OP_CLEAR_MASK |=>
    rf_r[$past(req.dst)] == ($past(rd_val) & ~$past(req.imm)))
    else $error("clear bits wrong");

  test_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
    take && req.op == balu_pkg::OP_TEST_REG |=>
    rf_r[$past(req.dst)] == $past(rd_val) &&
    flags_r.z == ($past(rd_val) == 8'h00))
    else $error("test changed register");

endmodule : balu_core

//--- balu_pkg.sv
// Shared constants and types for the byte arithmetic and logic datapath
package balu_pkg;

  // ==========================================================================
  // Bus map
  localparam logic [7:0] ADR_RF_LAST = 8'h7C;
  localparam logic [7:0] ADR_STATUS = 8'h80;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] BYTE_ALL = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ==========================================================================
  // Operations
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ADD = 4'h1,
    OP_ADC = 4'h2,
    OP_SUB = 4'h3,
    OP_SUB_BORROW = 4'h4,
    OP_SUB_IMM = 4'h5,
    OP_SUB_IMM_BORROW = 4'h6,
    OP_WORD_ADD = 4'h7,
    OP_WORD_SUB = 4'h8,
    OP_AND = 4'h9,
    OP_AND_IMM = 4'hA,
    OP_OR = 4'hB,
    OP_OR_IMM = 4'hC,
    OP_SET_MASK = 4'hD,
    OP_CLEAR_MASK = 4'hE,
    OP_TEST_REG = 4'hF
  } balu_op_type;

  typedef enum logic [0:0] {
    ST_IDLE = 1'h0,
    ST_WORD_HI = 1'h1
  } balu_state_type;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic valid;
    balu_op_type op;
    logic [4:0] dst;
    logic [4:0] src;
    logic [7:0] imm;
  } balu_req_type;

  // Bit order gives H5 S4 V3 N2 Z1 C0 in the status word
  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } balu_flags_type;

  typedef struct packed {
    logic c;
    logic h;
    logic v;
    logic [7:0] r;
  } balu_arith_type;

endpackage : balu_pkg

//--- balu_decoder_model.sv
// Decoder stand-in that issues datapath requests and waits for acceptance
`timescale 1ns/1ps
module balu_decoder_model (
  input wire logic clk,
  input wire logic req_ready_r,
  output balu_pkg::balu_req_type req
);
  // ====================
  // Request driver
  initial begin
    req = '0;
  end

  task automatic issue(input logic [3:0] op, input logic [4:0] dst,
                       input logic [4:0] src, input logic [7:0] imm);
    req <= '{1'h1, balu_pkg::balu_op_type'(op), dst, src, imm};
    do @(posedge clk); while (req_ready_r !== 1'h1);
  endtask : issue

  // Idle fields flip so a stale request is never mistaken for a new one
  task automatic idle();
    req <= '{1'h0, balu_pkg::balu_op_type'(~req.op), ~req.dst, ~req.src,
             ~req.imm};
  endtask : idle
endmodule : balu_decoder_model

//--- test_byte_alu_arith_logic.sv
// Self-checking bench for the byte arithmetic and logic datapath
`timescale 1ns/1ps
module test_byte_alu_arith_logic;
  // ====================
  // Signals
  typedef struct packed {
    logic [3:0] op;
    logic [7:0] a, b, imm, fin, er, eh, ef;
  } balu_row_type;
  logic clk;
  logic arst_n;
  balu_pkg::balu_req_type req;
  logic req_ready_r, done_r, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  balu_pkg::balu_flags_type flags_r;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, sel_v;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [4:0] d, s;
  int fails, tests_run, cycles, lat;
  // Rows: op, dst, dst+1 or source, imm, flags in, dst out, dst+1 out, flags
  balu_row_type rows [21] = '{
    60'h1_0F_01_00_00_10_01_20, 60'h1_80_80_00_10_00_80_1B,
    60'h2_7F_00_00_01_80_00_2C, 60'h3_10_01_00_00_0F_01_20,
    60'h3_00_01_00_00_FF_01_25, 60'h4_05_04_00_03_00_04_02,
    60'h4_05_04_00_01_00_04_00, 60'h5_80_33_01_10_7F_33_38,
    60'h6_10_33_0F_01_00_33_20, 60'h9_F0_8F_00_3F_80_8F_35,
    60'hA_0F_33_F0_08_00_33_02, 60'hB_00_00_00_21_00_00_23,
    60'hC_01_33_80_00_81_33_04, 60'hD_40_33_04_08_44_33_00,
    60'hE_FF_33_0F_01_F0_33_05, 60'hF_00_55_00_3C_00_55_32,
    60'h7_FF_00_01_20_00_01_20, 60'h7_FF_FF_01_00_00_00_03,
    60'h7_FF_7F_01_00_00_80_0C, 60'h8_00_00_01_00_FF_FF_15,
    60'h8_00_80_01_00_FF_7F_18};

  balu_core i_balu_core (.clk(clk), .arst_n(arst_n), .req(req),
    .req_ready_r(req_ready_r), .done_r(done_r), .flags_r(flags_r),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  balu_decoder_model i_balu_decoder_model (.clk(clk),
    .req_ready_r(req_ready_r), .req(req));

  // ====================
  // Clock and timeout
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  // ====================
  // Tasks
  task automatic cmp(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [7:0] dat, output logic [31:0] q);
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_sel_i <= sel_v;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, dat};
    do @(posedge clk); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb

  task automatic rdchk(input string name, input logic [7:0] adr,
                       input logic [7:0] exp);
    wb(1'h0, adr, 8'h00, rd);
    cmp(name, {24'h0, exp}, rd);
  endtask : rdchk

  task automatic wait_done();
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
    end while (done_r !== 1'h1 && lat < 8);
  endtask : wait_done

  task automatic chk_reset();
    cmp("ready", 32'h1, {31'h0, req_ready_r});
    cmp("done", 32'h0, {31'h0, done_r});
    cmp("flags", 32'h0, {26'h0, flags_r});
    cmp("ack", 32'h0, {31'h0, wb_ack_o});
    cmp("rdata", 32'h0, wb_dat_o);
  endtask : chk_reset

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // ====================
  // Main sequence
  initial begin
    arst_n = 1'h0;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    sel_v = 4'hF;
    wb_dat_i = 32'h0;
    repeat (16) @(posedge clk);
    chk_reset();
    arst_n <= 1'h1;
    @(posedge clk);
    chk_reset();
    $display("test reset done");
    // Row dst walks up so one word row wraps its pair from 31 to 0
    foreach (rows[i]) begin
      d = 5'(i + 15);
      s = d + 5'h1;
      wb(1'h1, {1'h0, d, 2'h0}, rows[i].a, rd);
      wb(1'h1, {1'h0, s, 2'h0}, rows[i].b, rd);
      wb(1'h1, 8'h80, rows[i].fin, rd);
      i_balu_decoder_model.issue(rows[i].op, d, s, rows[i].imm);
      i_balu_decoder_model.idle();
      wait_done();
      cmp("cycles", (rows[i].op == 4'h7 || rows[i].op == 4'h8) ? 2 : 1,
          32'(lat));
      rdchk("dst", {1'h0, d, 2'h0}, rows[i].er);
      rdchk("dst_plus_one", {1'h0, s, 2'h0}, rows[i].eh);
      rdchk("status", 8'h80, rows[i].ef);
      cmp("flags_port", {24'h0, rows[i].ef}, {26'h0, flags_r});
    end
    $display("test rows done");
    // Word op followed at once by a byte op that must wait its turn
    wb(1'h1, 8'h10, 8'h00, rd);
    wb(1'h1, 8'h14, 8'h80, rd);
    wb(1'h1, 8'h18, 8'h01, rd);
    wb(1'h1, 8'h1C, 8'h02, rd);
    wb(1'h1, 8'h80, 8'h00, rd);
    i_balu_decoder_model.issue(4'h7, 5'h4, 5'h0, 8'h01);
    i_balu_decoder_model.issue(4'h1, 5'h6, 5'h7, 8'h00);
    i_balu_decoder_model.idle();
    wait_done();
    cmp("b2b_cycles", 32'h1, 32'(lat));
    rdchk("b2b_low", 8'h10, 8'h01);
    rdchk("b2b_high", 8'h14, 8'h80);
    rdchk("b2b_sum", 8'h18, 8'h03);
    rdchk("b2b_status", 8'h80, 8'h10);
    $display("test back_to_back done");
    // Empty operation: no done pulse, register and flags untouched
    i_balu_decoder_model.issue(4'h0, 5'h6, 5'h7, 8'hFF);
    i_balu_decoder_model.idle();
    wait_done();
    cmp("nop_no_done", 32'h8, 32'(lat));
    rdchk("nop_keep", 8'h18, 8'h03);
    rdchk("nop_status", 8'h80, 8'h10);
    $display("test nop done");
    // Bus corner cases: masked write, unmapped place, unused status bits
    wb(1'h1, 8'h0C, 8'h5A, rd);
    sel_v = 4'h0;
    wb(1'h1, 8'h0C, 8'hA5, rd);
    sel_v = 4'hF;
    rdchk("masked_write", 8'h0C, 8'h5A);
    wb(1'h1, 8'h84, 8'hFF, rd);
    rdchk("unmapped", 8'h84, 8'h00);
    wb(1'h1, 8'h80, 8'hFF, rd);
    rdchk("status_width", 8'h80, 8'h3F);
    $display("test bus done");
    arst_n <= 1'h0;
    repeat (2) @(posedge clk);
    chk_reset();
    arst_n <= 1'h1;
    rdchk("status_after_reset", 8'h80, 8'h00);
    $display("test mid_reset done");
    report_and_stop();
  end
endmodule : test_byte_alu_arith_logic
